// ### rtl/word_xfer_pkg.sv
// Purpose: shared constants for the host/unit word transfer pair
// Assumes: one core clock, synchronous active-low reset on both ends
// Notes: register map applies to the host end's APB slave
package word_xfer_pkg;
    localparam logic [15:0] CODE_ERR_CLEAR = 16'hEC00;
    localparam logic [3:0] KIND_ONE_WORD = 4'h0;
    localparam logic [3:0] KIND_THREE_WORD = 4'h1;
    localparam logic [7:0] MAX_HOST_WORDS = 8'h80;
    localparam logic [15:0] MAX_DM_ADDR = 16'h1A00;
    localparam logic [7:0] MAX_UNIT_NO = 8'h0F;
    localparam logic [7:0] TRIPLE = 8'h03;
    localparam int STATUS_ERR_BIT = 7;
    localparam logic [15:0] STATUS_RESET = 16'h0000;
    localparam logic [7:0] REFRESH_MIN = 8'h02;
    localparam logic [11:0] REG_CTRL = 12'h000;
    localparam logic [11:0] REG_CODE = 12'h004;
    localparam logic [11:0] REG_COUNT = 12'h008;
    localparam logic [11:0] REG_DM = 12'h00C;
    localparam logic [11:0] REG_UNIT = 12'h010;
    localparam logic [11:0] REG_PTR = 12'h014;
    localparam logic [11:0] REG_STATUS = 12'h018;
    localparam logic [11:0] REG_MEM_ADDR = 12'h01C;
    localparam logic [11:0] REG_MEM_DATA = 12'h020;
    localparam int CTRL_START = 0;
    localparam int CTRL_WRITE = 1;
    localparam int CTRL_INDIRECT = 2;
    localparam int CTRL_REMOTE = 3;
    localparam int STAT_BUSY = 0;
    localparam int STAT_INSTR_ERR = 1;
    localparam int STAT_WRITE_DONE = 2;
    localparam int STAT_UNIT_ERR = 3;
    localparam logic [3:0] CTRL_RESET = 4'h0;
    localparam logic [15:0] WORD_RESET = 16'h0000;
endpackage : word_xfer_pkg

// ### rtl/unit_link_if.sv
// Purpose: link between the host controller end and the motion unit end
// Assumes: both ends on core_clk; every signal is driven from a flip-flop
// Notes: no clocking block; the bench joins the two ends through this
`timescale 1ns/1ns
interface unit_link_if;
    logic cmd_valid;
    logic cmd_write;
    logic [15:0] cmd_code;
    logic [7:0] cmd_count;
    logic wr_valid;
    logic [15:0] wr_word;
    logic io_refresh;
    logic dn_valid;
    logic [15:0] dn_word;
    logic ack;
    logic ack_ok;
    logic rd_valid;
    logic [15:0] rd_word;
    logic [15:0] status7;
    logic unit_busy;
    logic up_valid;
    logic [15:0] up_addr;
    logic [15:0] up_word;
    logic dn_req;
    logic [15:0] dn_addr;
    modport host_end (output cmd_valid, cmd_write, cmd_code, cmd_count,
        wr_valid, wr_word, io_refresh, dn_valid, dn_word,
        input ack, ack_ok, rd_valid, rd_word, status7, unit_busy,
        up_valid, up_addr, up_word, dn_req, dn_addr);
    modport unit_end (input cmd_valid, cmd_write, cmd_code, cmd_count,
        wr_valid, wr_word, io_refresh, dn_valid, dn_word,
        output ack, ack_ok, rd_valid, rd_word, status7, unit_busy,
        up_valid, up_addr, up_word, dn_req, dn_addr);
endinterface : unit_link_if

// ### rtl/bcd_word_check.sv
// Purpose: check a packed BCD word and convert it to binary
// Assumes: purely combinational
// Notes: used for the word count and the indirect data address
`timescale 1ns/1ns
module bcd_word_check #(
    parameter int DIGITS = 4
) (
    input wire logic [4*DIGITS-1:0] bcd,
    output logic ok,
    output logic [4*DIGITS-1:0] bin
);
    localparam int W = 4 * DIGITS;
    logic [DIGITS-1:0] dig_ok;
    genvar i;
    for (i = 0; i < DIGITS; i++) begin : g_dig
        assign dig_ok[i] = bcd[4*i+:4] <= 4'h9;
    end
    assign ok = &dig_ok;
    always_comb begin
        bin = '0;
        for (int j = DIGITS - 1; j >= 0; j--) begin
            bin = W'(bin * W'(4'hA) + W'(bcd[4*j+:4]));
        end
    end
endmodule : bcd_word_check

// ### rtl/unit_word_xfer.sv
// Purpose: motion unit end: host commands, shared variable array, own
//          transfers at I/O refresh
// Assumes: host keeps its side of the link protocol
// Notes: one host command and one own transfer may be outstanding
// Contract
// RL1: error-clear code EC00 clears transfer error flag
// RL2: source contents ignored for error-clear command
// RL3: older host packs unit number, amount 001
// RL4: newer host: unit number 0..F, amount 0001
// RL5: host error on bad, zero or >128 count
// RL6: host error on indirect address >6656 or non-BCD
// RL7: host error on unit number >F or remote rack
// RL8: host error on failure, cleared when settings valid
// RL9: host write-done set on good write, else cleared
// RL10: unsupported code sets error bit 07, word seven
// RL11: three-word count not multiple of three errors
// RL12: address plus amount outside storage errors
// RL13: request overflow sets transfer error flag
// RL14: three-word data layout never checked
// RL15: unit starts own reads and writes
// RL16: own transfer moves at most 127 words
// RL17: own transfers use one-word format only
// RL18: own transfer data moves only during refresh
// RL19: requesting task stalled until transfer completes
// RL20: error flag holds until clear code or reset
//
// Added by the designer: the register offsets and register access over APB.
`timescale 1ns/1ns
module unit_word_xfer import word_xfer_pkg::*; #(
    parameter int VR_DEPTH = 1024
) (
    input wire logic core_clk,
    input wire logic rstn,
    unit_link_if.unit_end link,
    input wire logic task_req,
    input wire logic task_write,
    input wire logic [15:0] task_vr_addr,
    input wire logic [15:0] task_host_addr,
    input wire logic [6:0] task_words,
    output logic task_stall,
    output logic xfer_err
);
    localparam int AW = $clog2(VR_DEPTH);
    typedef enum {H_IDLE, H_WR, H_RD} hstate_e;
    typedef enum {T_IDLE, T_WAIT, T_RUN, T_END} tstate_e;

    logic [15:0] vr_q [VR_DEPTH];
    hstate_e h_state_q;
    tstate_e t_state_q;
    logic [15:0] h_ptr_q;
    logic [7:0] h_left_q;
    logic h_bad_q;
    logic h_clear_q;
    logic ack_q, ack_ok_q, rd_valid_q;
    logic [15:0] rd_word_q;
    logic [15:0] status7_q;
    logic stall_q, busy_q, t_write_q;
    logic [15:0] t_vr_q, t_host_q, t_rx_q;
    logic [6:0] t_left_q, t_rx_left_q;
    logic up_valid_q, dn_req_q;
    logic [15:0] up_addr_q, up_word_q, dn_addr_q;
    logic refr_seen_q; // late start could outlive the refresh window

    logic [3:0] kind;
    logic is_clear, code_ok, range_ok, mult_ok, cmd_bad;
    logic task_bad, err_set, err_clr;
    logic [16:0] cmd_end, task_end;

    assign kind = link.cmd_code[15:12];
    assign is_clear = link.cmd_write && link.cmd_code == CODE_ERR_CLEAR;
    assign code_ok = kind == KIND_ONE_WORD || kind == KIND_THREE_WORD; // RL10
    assign cmd_end = 17'(link.cmd_code[11:0]) + 17'(link.cmd_count);
    assign range_ok = cmd_end <= 17'(VR_DEPTH); // RL12
    assign mult_ok = kind != KIND_THREE_WORD
        || (link.cmd_count % TRIPLE) == 8'h00; // RL11
    assign cmd_bad = !is_clear && (!code_ok || !range_ok || !mult_ok
        || link.cmd_count == 8'h00);
    // width of task_words already caps a transfer at 127 words
    assign task_end = 17'(task_vr_addr) + 17'(task_words);
    assign task_bad = task_words == 7'h00
        || task_end > 17'(VR_DEPTH); // RL16 RL12

    assign link.ack = ack_q;
    assign link.ack_ok = ack_ok_q;
    assign link.rd_valid = rd_valid_q;
    assign link.rd_word = rd_word_q;
    assign link.status7 = status7_q;
    assign link.unit_busy = busy_q;
    assign link.up_valid = up_valid_q;
    assign link.up_addr = up_addr_q;
    assign link.up_word = up_word_q;
    assign link.dn_req = dn_req_q;
    assign link.dn_addr = dn_addr_q;
    assign task_stall = stall_q;
    assign xfer_err = status7_q[STATUS_ERR_BIT];

    // host-issued commands
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            h_state_q <= H_IDLE;
            h_ptr_q <= WORD_RESET;
            h_left_q <= 8'h00;
            h_bad_q <= 1'b0;
            h_clear_q <= 1'b0;
            ack_q <= 1'b0;
            ack_ok_q <= 1'b0;
            rd_valid_q <= 1'b0;
            rd_word_q <= WORD_RESET;
        end else begin
            ack_q <= 1'b0;
            rd_valid_q <= 1'b0;
            case (h_state_q)
                H_IDLE: begin
                    if (link.cmd_valid) begin
                        h_ptr_q <= {4'h0, link.cmd_code[11:0]};
                        h_left_q <= link.cmd_count;
                        h_bad_q <= cmd_bad;
                        h_clear_q <= is_clear;
                        if (link.cmd_write && link.cmd_count != 8'h00) begin
                            h_state_q <= H_WR;
                        end else if (!link.cmd_write && !cmd_bad) begin
                            h_state_q <= H_RD;
                        end else begin
                            ack_q <= 1'b1;
                            ack_ok_q <= 1'b0;
                        end
                    end
                end
                H_WR: begin
                    if (link.wr_valid) begin
                        h_ptr_q <= h_ptr_q + 16'h0001;
                        h_left_q <= h_left_q - 8'h01;
                        if (h_left_q == 8'h01) begin
                            ack_q <= 1'b1;
                            ack_ok_q <= !h_bad_q;
                            h_state_q <= H_IDLE;
                        end
                    end
                end
                H_RD: begin
                    rd_valid_q <= 1'b1;
                    rd_word_q <= vr_q[h_ptr_q[AW-1:0]];
                    h_ptr_q <= h_ptr_q + 16'h0001;
                    h_left_q <= h_left_q - 8'h01;
                    if (h_left_q == 8'h01) begin
                        ack_q <= 1'b1;
                        ack_ok_q <= 1'b1;
                        h_state_q <= H_IDLE;
                    end
                end
                default: h_state_q <= H_IDLE;
            endcase
        end
    end

    // sticky transfer error: a new error beats a clear in the same cycle
    assign err_set = (link.cmd_valid && h_state_q == H_IDLE && cmd_bad)
        || (link.cmd_valid && h_state_q != H_IDLE)
        || (task_req && t_state_q != T_IDLE)
        || (task_req && t_state_q == T_IDLE && task_bad); // RL13
    assign err_clr = h_state_q == H_WR && link.wr_valid && h_clear_q
        && h_left_q == 8'h01; // RL1 RL20
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            status7_q <= STATUS_RESET;
        end else if (err_set) begin
            status7_q[STATUS_ERR_BIT] <= 1'b1; // RL10 RL20
        end else if (err_clr) begin
            status7_q[STATUS_ERR_BIT] <= 1'b0; // RL1
        end
    end

    // own transfers, one word per value, only while refresh is open
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            t_state_q <= T_IDLE;
            stall_q <= 1'b0;
            busy_q <= 1'b0;
            t_write_q <= 1'b0;
            t_vr_q <= WORD_RESET;
            t_host_q <= WORD_RESET;
            t_rx_q <= WORD_RESET;
            t_left_q <= 7'h00;
            t_rx_left_q <= 7'h00;
            up_valid_q <= 1'b0;
            up_addr_q <= WORD_RESET;
            up_word_q <= WORD_RESET;
            dn_req_q <= 1'b0;
            dn_addr_q <= WORD_RESET;
            refr_seen_q <= 1'b0;
        end else begin
            up_valid_q <= 1'b0;
            dn_req_q <= 1'b0;
            refr_seen_q <= link.io_refresh;
            if (link.dn_valid && t_rx_left_q != 7'h00) begin
                t_rx_q <= t_rx_q + 16'h0001;
                t_rx_left_q <= t_rx_left_q - 7'h01;
            end
            case (t_state_q)
                T_IDLE: begin
                    if (task_req && !task_bad) begin
                        t_write_q <= task_write; // RL15
                        t_vr_q <= task_vr_addr;
                        t_rx_q <= task_vr_addr;
                        t_host_q <= task_host_addr;
                        t_left_q <= task_words;
                        t_rx_left_q <= task_write ? 7'h00 : task_words;
                        stall_q <= 1'b1; // RL19
                        t_state_q <= T_WAIT;
                    end
                end
                T_WAIT: begin
                    if (link.io_refresh && !refr_seen_q) begin
                        busy_q <= 1'b1; // RL18
                        t_state_q <= T_RUN;
                    end
                end
                T_RUN: begin
                    if (t_write_q) begin
                        up_valid_q <= 1'b1; // RL17
                        up_addr_q <= t_host_q;
                        up_word_q <= vr_q[t_vr_q[AW-1:0]];
                    end else begin
                        dn_req_q <= 1'b1;
                        dn_addr_q <= t_host_q;
                    end
                    t_vr_q <= t_vr_q + 16'h0001;
                    t_host_q <= t_host_q + 16'h0001;
                    t_left_q <= t_left_q - 7'h01;
                    if (t_left_q == 7'h01) begin
                        t_state_q <= T_END;
                    end
                end
                T_END: begin
                    if (t_rx_left_q == 7'h00) begin
                        busy_q <= 1'b0;
                        stall_q <= 1'b0; // RL19
                        t_state_q <= T_IDLE;
                    end
                end
                default: t_state_q <= T_IDLE;
            endcase
        end
    end

    // error-clear data is dropped; three-word data is stored as given
    always_ff @(posedge core_clk) begin
        if (h_state_q == H_WR && link.wr_valid && !h_bad_q
            && !h_clear_q) begin // RL2 RL14
            vr_q[h_ptr_q[AW-1:0]] <= link.wr_word;
        end else if (link.dn_valid && t_rx_left_q != 7'h00) begin
            vr_q[t_rx_q[AW-1:0]] <= link.dn_word;
        end
    end
endmodule : unit_word_xfer

// ### rtl/host_word_xfer.sv
// Purpose: controller end: APB-driven instructions, scan refresh, flags
// Assumes: one unit on the link; software keeps count and unit number
// Notes: refresh waits for an instruction to finish before it opens
`timescale 1ns/1ns
module host_word_xfer import word_xfer_pkg::*; #(
    parameter int MEM_DEPTH = 256,
    parameter logic [15:0] SCAN_CYCLES = 16'h0040
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    unit_link_if.host_end link
);
    localparam int AW = $clog2(MEM_DEPTH);
    typedef enum {S_IDLE, S_SEND, S_WAIT, S_RECV, S_REFR} hstate_e;

    function automatic logic reg_hit(input logic [11:0] a);
        reg_hit = a == REG_CTRL || a == REG_CODE || a == REG_COUNT
            || a == REG_DM || a == REG_UNIT || a == REG_PTR
            || a == REG_STATUS || a == REG_MEM_ADDR || a == REG_MEM_DATA;
    endfunction : reg_hit

    logic [15:0] mem_q [MEM_DEPTH];
    hstate_e state_q;
    logic [3:0] ctrl_q;
    logic [15:0] code_q, count_q, dm_q, ptr_q, mem_addr_q;
    logic [7:0] unit_q, left_q, refr_q;
    logic [15:0] scan_q;
    logic er_q, eq_q;
    logic pready_q, pslverr_q;
    logic [31:0] prdata_q;
    logic cmd_valid_q, wr_valid_q, refresh_q, dn_valid_q;
    logic [15:0] wr_word_q, dn_word_q;
    logic apb_acc, apb_wr;
    logic cnt_ok, dm_ok, cnt_bcd, dm_bcd, all_ok;
    logic [15:0] cnt_bin, dm_bin;

    bcd_word_check #(.DIGITS(4)) u_cnt (.bcd(count_q), .ok(cnt_bcd),
        .bin(cnt_bin));
    bcd_word_check #(.DIGITS(4)) u_dm (.bcd(dm_q), .ok(dm_bcd),
        .bin(dm_bin));

    assign cnt_ok = cnt_bcd && cnt_bin != WORD_RESET
        && cnt_bin <= 16'(MAX_HOST_WORDS); // RL5
    assign dm_ok = !ctrl_q[CTRL_INDIRECT]
        || (dm_bcd && dm_bin <= MAX_DM_ADDR); // RL6
    assign all_ok = cnt_ok && dm_ok && unit_q <= MAX_UNIT_NO
        && !ctrl_q[CTRL_REMOTE]; // RL7

    // access phase is answered after one wait cycle
    assign apb_acc = psel && penable && !pready_q;
    assign apb_wr = psel && penable && pready_q && pwrite && !pslverr_q;
    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign link.cmd_valid = cmd_valid_q;
    assign link.cmd_write = ctrl_q[CTRL_WRITE];
    assign link.cmd_code = code_q;
    assign link.cmd_count = left_q;
    assign link.wr_valid = wr_valid_q;
    assign link.wr_word = wr_word_q;
    assign link.io_refresh = refresh_q;
    assign link.dn_valid = dn_valid_q;
    assign link.dn_word = dn_word_q;

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else begin
            pready_q <= apb_acc;
            pslverr_q <= apb_acc && !reg_hit(paddr);
            prdata_q <= 32'h0000_0000;
            if (apb_acc && !pwrite) begin
                if (paddr == REG_CTRL) begin
                    prdata_q <= 32'(ctrl_q);
                end else if (paddr == REG_CODE) begin
                    prdata_q <= 32'(code_q);
                end else if (paddr == REG_COUNT) begin
                    prdata_q <= 32'(count_q);
                end else if (paddr == REG_DM) begin
                    prdata_q <= 32'(dm_q);
                end else if (paddr == REG_UNIT) begin
                    prdata_q <= 32'(unit_q);
                end else if (paddr == REG_PTR) begin
                    prdata_q <= 32'(ptr_q);
                end else if (paddr == REG_STATUS) begin
                    prdata_q[STAT_BUSY] <= state_q != S_IDLE;
                    prdata_q[STAT_INSTR_ERR] <= er_q;
                    prdata_q[STAT_WRITE_DONE] <= eq_q;
                    prdata_q[STAT_UNIT_ERR] <= link.status7[STATUS_ERR_BIT];
                end else if (paddr == REG_MEM_ADDR) begin
                    prdata_q <= 32'(mem_addr_q);
                end else if (paddr == REG_MEM_DATA) begin
                    prdata_q <= 32'(mem_q[mem_addr_q[AW-1:0]]);
                end
            end
        end
    end

    // software settings; start bit self-clears when taken
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            ctrl_q <= CTRL_RESET;
            code_q <= WORD_RESET;
            count_q <= WORD_RESET;
            dm_q <= WORD_RESET;
            unit_q <= 8'h00;
            mem_addr_q <= WORD_RESET;
        end else begin
            if (apb_wr && paddr == REG_CTRL) begin
                ctrl_q <= pwdata[3:0];
            end else if (state_q == S_IDLE && ctrl_q[CTRL_START]
                && scan_q < SCAN_CYCLES) begin
                ctrl_q[CTRL_START] <= 1'b0;
            end
            if (apb_wr && paddr == REG_CODE) code_q <= pwdata[15:0];
            if (apb_wr && paddr == REG_COUNT) count_q <= pwdata[15:0];
            if (apb_wr && paddr == REG_DM) dm_q <= pwdata[15:0];
            if (apb_wr && paddr == REG_UNIT) unit_q <= pwdata[7:0];
            if (apb_wr && paddr == REG_MEM_ADDR) begin
                mem_addr_q <= pwdata[15:0];
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            state_q <= S_IDLE;
            ptr_q <= WORD_RESET;
            left_q <= 8'h00;
            refr_q <= 8'h00;
            scan_q <= WORD_RESET;
            er_q <= 1'b0;
            eq_q <= 1'b0;
            cmd_valid_q <= 1'b0;
            wr_valid_q <= 1'b0;
            wr_word_q <= WORD_RESET;
            refresh_q <= 1'b0;
            dn_valid_q <= 1'b0;
            dn_word_q <= WORD_RESET;
        end else begin
            cmd_valid_q <= 1'b0;
            dn_valid_q <= 1'b0;
            if (state_q != S_REFR) scan_q <= scan_q + 16'h0001;
            if (apb_wr && paddr == REG_PTR) ptr_q <= pwdata[15:0];
            case (state_q)
                S_IDLE: begin
                    if (scan_q >= SCAN_CYCLES) begin
                        refresh_q <= 1'b1;
                        refr_q <= 8'h00;
                        state_q <= S_REFR;
                    end else if (ctrl_q[CTRL_START]) begin
                        if (all_ok) begin
                            cmd_valid_q <= 1'b1;
                            left_q <= cnt_bin[7:0];
                            state_q <= ctrl_q[CTRL_WRITE] ? S_SEND : S_RECV;
                        end else begin
                            er_q <= 1'b1; // RL5 RL6 RL7
                            eq_q <= 1'b0; // RL9
                        end
                    end
                end
                S_SEND: begin
                    wr_valid_q <= left_q != 8'h00;
                    if (left_q != 8'h00) begin
                        wr_word_q <= mem_q[ptr_q[AW-1:0]];
                        ptr_q <= ptr_q + 16'h0001;
                        left_q <= left_q - 8'h01;
                    end else begin
                        state_q <= S_WAIT;
                    end
                end
                S_WAIT, S_RECV: begin
                    if (link.rd_valid) ptr_q <= ptr_q + 16'h0001;
                    if (link.ack) begin
                        er_q <= !link.ack_ok; // RL8
                        eq_q <= ctrl_q[CTRL_WRITE] && link.ack_ok; // RL9
                        state_q <= S_IDLE;
                    end
                end
                S_REFR: begin
                    if (refr_q != 8'hFF) refr_q <= refr_q + 8'h01;
                    if (link.dn_req) begin
                        dn_valid_q <= 1'b1;
                        dn_word_q <= mem_q[link.dn_addr[AW-1:0]];
                    end
                    if (refr_q >= REFRESH_MIN && !link.unit_busy) begin
                        refresh_q <= 1'b0; // RL18
                        scan_q <= WORD_RESET;
                        state_q <= S_IDLE;
                    end
                end
                default: state_q <= S_IDLE;
            endcase
        end
    end

    // unit pushes only in refresh, read data only outside it
    always_ff @(posedge core_clk) begin
        if (link.up_valid) begin
            mem_q[link.up_addr[AW-1:0]] <= link.up_word;
        end else if (state_q == S_RECV && link.rd_valid) begin
            mem_q[ptr_q[AW-1:0]] <= link.rd_word;
        end else if (apb_wr && paddr == REG_MEM_DATA) begin
            mem_q[mem_addr_q[AW-1:0]] <= pwdata[15:0];
        end
    end
endmodule : host_word_xfer

// ### test/link_monitor.sv
// Purpose: link checks between the two ends
// Assumes: one clock domain
// Notes: sees the link only; host flags are judged by the bench
`timescale 1ns/1ns
module link_monitor import word_xfer_pkg::*; #(
    parameter int VR_DEPTH = 1024
) (
    input wire logic core_clk,
    input wire logic rstn,
    input wire logic cmd_valid,
    input wire logic [15:0] cmd_code,
    input wire logic [7:0] cmd_count,
    input wire logic io_refresh,
    input wire logic unit_busy,
    input wire logic up_valid,
    input wire logic dn_req,
    input wire logic ack,
    input wire logic ack_ok,
    input wire logic [15:0] status7
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rstn);
    logic [7:0] n_q;
    always_ff @(posedge core_clk)
        n_q <= (!rstn || !unit_busy) ? 8'h00
            : n_q + 8'(up_valid | dn_req);
    clear_err_a: assert property (ack && ack_ok &&
        cmd_code == CODE_ERR_CLEAR |-> ##[0:2] !status7[7])
        else $error("no clear");
    bad_code_a: assert property (cmd_valid && cmd_code[15:12] > 4'h1 &&
        cmd_code != CODE_ERR_CLEAR |-> ##[1:300] status7[7])
        else $error("code");
    status_bits_a: assert property (status7[15:8] == 8'h00 &&
        status7[6:0] == 7'h00) else $error("stray status bit");
    triple_count_a: assert property (cmd_valid &&
        cmd_code[15:12] == 4'h1 && cmd_count % TRIPLE != 8'h00
        |-> ##[1:300] status7[7]) else $error("cnt");
    range_check_a: assert property (cmd_valid &&
        cmd_code[15:12] == 4'h0 && cmd_code[11:0] + cmd_count > VR_DEPTH
        |-> ##[1:300] status7[7]) else $error("range");
    own_max_a: assert property (n_q <= 8'h7F) else $error("own count");
    refresh_only_a: assert property (up_valid || dn_req |-> io_refresh)
        else $error("outside refresh");
    err_hold_a: assert property ($fell(status7[7]) |->
        cmd_code == CODE_ERR_CLEAR) else $error("flag dropped");
endmodule : link_monitor

// ### test/tb.sv
// Purpose: bench for host and unit ends
// Assumes: scan shortened to 16 cycles
// Notes: status polled, since a start waits for the scan
`timescale 1ns/1ns
module tb import word_xfer_pkg::*; ;
    typedef struct packed {
        logic [3:0] c;
        logic [15:0] code, cnt, unit, dm;
        logic [3:0] e;
    } row_s;
    // ctrl, code, bcd count, unit, bcd dm, expected status
    row_s rows[17] = '{72'h300050001000000004, 72'h300050000000000002,
        72'h300000128000000004, 72'h300000129000000002,
        72'h31000000400000000A, 72'h3EC000001000000004,
        72'h30005001A000000002, 72'h33000000100000000A,
        72'h3EC000001000000004, 72'h300050001001000002,
        72'h30FFF000200000000A, 72'h31003000300000000C,
        72'hB0005000100000000A, 72'h30005000100000000C,
        72'h100050002000000008, 72'h70005000100006657A,
        72'h3EC000001000000004};
    logic core_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic task_req = 0, task_write = 0, task_stall, xfer_err;
    logic pready, pslverr, err;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [6:0] tw = '0;
    int fail_count = 0, check_count = 0;
    unit_link_if link();
    host_word_xfer #(.SCAN_CYCLES(16'h0010)) i_host_word_xfer(.core_clk,
        .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .link(link.host_end));
    unit_word_xfer i_unit_word_xfer(.core_clk, .rstn, .link(link.unit_end),
        .task_req, .task_write, .task_vr_addr(16'h0000),
        .task_host_addr(16'h0000), .task_words(tw), .task_stall, .xfer_err);
    link_monitor i_link_monitor(.core_clk, .rstn, .cmd_valid(link.cmd_valid),
        .cmd_code(link.cmd_code), .cmd_count(link.cmd_count),
        .io_refresh(link.io_refresh), .unit_busy(link.unit_busy),
        .up_valid(link.up_valid), .dn_req(link.dn_req), .ack(link.ack),
        .ack_ok(link.ack_ok), .status7(link.status7));
    initial forever #5 core_clk = ~core_clk;
    task automatic end_sim;
        if (fail_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_sim
    task automatic chk(input string n, input logic [31:0] e, s);
        check_count++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s exp %h got %h", n, e, s);
        end
    endtask : chk
    // one transfer, then an idle cycle so back-to-back calls never race
    task automatic apb(input logic w, logic [11:0] a, logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
        if (n >= 50) begin
            fail_count++;
            end_sim;
        end
    endtask : apb
    initial begin
        repeat (6) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        apb(1'b0, REG_STATUS, '0);
        chk("status", '0, rd);
        apb(1'b0, 12'h024, '0);
        chk("slverr", 32'h1, {31'h0, err});
        foreach (rows[i]) begin
            apb(1'b1, REG_UNIT, {16'h0000, rows[i].unit});
            apb(1'b1, REG_COUNT, {16'h0000, rows[i].cnt});
            apb(1'b1, REG_CODE, {16'h0000, rows[i].code});
            apb(1'b1, REG_DM, {16'h0000, rows[i].dm});
            apb(1'b1, REG_CTRL, {28'h0, rows[i].c});
            for (int n = 0; n < 100 && rd[3:0] !== rows[i].e; n++)
                apb(1'b0, REG_STATUS, '0);
            chk("status", 32'(rows[i].e), rd);
            chk("unit_err", 32'(rows[i].e[3]), 32'(rd[3]));
        end
        // 127-word push, pull with a refused overlap, zero-word refusal
        for (int k = 0; k < 3; k++) begin
            task_req <= 1'b1;
            task_write <= ~k[0];
            tw <= (k < 2) ? 7'h7F : 7'h00;
            @(posedge core_clk);
            task_req <= k == 1;
            @(posedge core_clk);
            task_req <= 1'b0;
            chk("stall", 32'(k < 2), 32'(task_stall));
            for (int n = 0; n < 3000 && task_stall !== 1'b0; n++)
                @(posedge core_clk);
            chk("done", '0, 32'(task_stall));
            chk("xfer_err", 32'(k > 0), 32'(xfer_err));
        end
        end_sim;
    end
endmodule : tb
